//--- wdcm_pkg.sv
// Purpose: Shared constants and types of the watchdog and clock monitor block.
// Assumes: APB slave with 32-bit data; one register per aligned word.
// Notes:   Byte address of a register is four times its register index.
package wdcm_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [9:0] IDX_SERVICE = 10'h01D; // Service register index.
    localparam logic [9:0] IDX_CONTROL = 10'h01E; // Control register index.
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h020; // Sticky event status index.
    localparam logic [9:0] IDX_IRQ_CLEAR = 10'h021; // Event clear index.
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h022; // Event enable index.
    localparam logic [11:0] ADDR_SERVICE = {IDX_SERVICE, 2'b00}; // Byte address.
    localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00}; // Byte address.
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00}; // Byte address.
    localparam logic [11:0] ADDR_IRQ_CLEAR = {IDX_IRQ_CLEAR, 2'b00}; // Byte address.
    localparam logic [11:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00}; // Byte address.

    // ************************************************************
    // Field layout and values
    // ************************************************************
    localparam int FLAG_POS = 4; // Reset-source flag bit.
    localparam int CME_POS = 3; // Clock monitor enable bit.
    localparam int WDE_POS = 2; // Watchdog enable bit.
    localparam int PSH_POS = 1; // Period select high bit.
    localparam int PSL_POS = 0; // Period select low bit.
    localparam logic [7:0] CONTROL_RESET = 8'h00; // Control reset value, five bits used.
    localparam logic [7:0] SERVICE_KEY_FIRST = 8'h55; // First service byte.
    localparam logic [7:0] SERVICE_KEY_SECOND = 8'hAA; // Second service byte.
    localparam logic [2:0] EVT_TIMEOUT = 3'h1; // Event mask: watchdog expiry.
    localparam logic [2:0] EVT_CLKFAIL = 3'h2; // Event mask: clock monitor fault.
    localparam logic [2:0] EVT_SERVICED = 3'h4; // Event mask: completed service.

    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam int unsigned WD_BASE_DIV = 32768; // E clock divided by two to the 15th.
    localparam logic [4:0] SYSRST_CYCLES = 5'h10; // Length of the system reset pulse.
    localparam logic [15:0] CLKMON_MIN_CYCLES = 16'h0010; // Least clocks per reference tick.

    // Control register fields as carried through the block.
    typedef struct packed {
        logic reset_source_flag; // Last reset came from this block.
        logic clock_monitor_enable; // Clock monitor may reset the system.
        logic watchdog_enable; // Watchdog expiry may reset the system.
        logic period_select_hi; // Period select, upper bit.
        logic period_select_lo; // Period select, lower bit.
    } wdcm_ctrl_t;

    // Service sequence state.
    typedef enum logic [0:0] {
        WDCM_SVC_IDLE = 1'b0,
        WDCM_SVC_ARMED = 1'b1
    } wdcm_svc_t;

endpackage

//--- wdcm_top.sv
// Purpose: Watchdog timer with clock monitor behind an APB register slave.
// Assumes: E clock equals pclk; ref_clk_in is a slow free-running reference pin.
// Notes:   sys_reset_out is the system reset request; presetn is power-on reset.
//
// Summary of operation
// - Flag marks resets caused by this block
// - Clock monitor resets only when enabled
// - Watchdog expiry resets only when enabled
// - Period bits set by software, cleared by reset
// - Timeout is 2^15 times 1,4,16,64
// - Other accesses keep the pending sequence
// - Service register reads have no effect
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module wdcm_top #(
    parameter int unsigned BASE_DIV = wdcm_pkg::WD_BASE_DIV // Base timeout in clocks.
) (
    input wire logic pclk, // APB clock, also the E clock.
    input wire logic presetn, // Power-on reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic ref_clk_in, // Slow reference clock pin.
    output logic sys_reset_out, // System reset request, active high.
    output logic irq // Level interrupt.
);

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic pready_q; // Answer flop; one wait state per access.
    logic pslverr_q; // Error flop.
    logic [31:0] prdata_q; // Read data flop.
    logic access_go; // Access phase before the answer.
    logic access_done; // Edge at which a transfer takes effect.
    logic wr_done; // Completing write.
    logic rd_done; // Completing read.
    logic addr_hit; // Address is mapped.
    logic [31:0] rd_mux; // Read data for the current address.

    assign access_go = psel && penable && !pready_q;
    assign access_done = psel && penable && pready_q;
    assign wr_done = access_done && pwrite;
    assign rd_done = access_done && !pwrite;
    assign addr_hit = (paddr == wdcm_pkg::ADDR_SERVICE) || (paddr == wdcm_pkg::ADDR_CONTROL)
        || (paddr == wdcm_pkg::ADDR_IRQ_STATUS) || (paddr == wdcm_pkg::ADDR_IRQ_CLEAR)
        || (paddr == wdcm_pkg::ADDR_IRQ_ENABLE);

    // ************************************************************
    // State declarations
    // ************************************************************
    wdcm_pkg::wdcm_ctrl_t ctrl_q; // Control register.
    wdcm_pkg::wdcm_svc_t svc_q; // Service sequence state.
    logic [21:0] wd_cnt_q; // Watchdog count in E clocks.
    logic [21:0] wd_limit; // Selected timeout in E clocks.
    logic wd_expire; // Count reached the selected period.
    logic svc_restart; // Completed service sequence.
    logic clk_fail; // Clock monitor fault this cycle.
    logic trigger; // A reset cause fires this cycle.
    logic sys_reset_q; // System reset output flop.
    logic [4:0] rst_cnt_q; // Remaining reset pulse length.
    logic ref_s1_q, ref_s2_q, ref_s3_q; // Reference synchroniser.
    logic ref_lvl_q; // Accepted reference level.
    logic ref_rise; // Accepted rising edge of reference.
    logic [15:0] gap_q; // Clocks since the last reference edge.
    logic [2:0] status_q; // Sticky event status.
    logic [2:0] enable_q; // Event enables.
    logic [2:0] evt_set; // Events this cycle.
    logic [2:0] evt_clr; // Clears written this cycle.
    logic irq_q; // Interrupt flop.

    // Read data selected combinationally, registered when the answer is given.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            // Service reads return zero; no meaningful value exists.
            wdcm_pkg::ADDR_CONTROL: rd_mux = {27'h000_0000, ctrl_q};
            wdcm_pkg::ADDR_IRQ_STATUS: rd_mux = {29'h0000_0000, status_q};
            wdcm_pkg::ADDR_IRQ_ENABLE: rd_mux = {29'h0000_0000, enable_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Ready rises one cycle into the access phase and drops after the edge it is seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access_go;
            pslverr_q <= access_go && !addr_hit;
            if (access_go && !pwrite) begin
                prdata_q <= rd_mux;
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Flag survives a system reset so software can see why it restarted;
    // only power-on clears it. The rest of the control state follows system reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= wdcm_pkg::wdcm_ctrl_t'(wdcm_pkg::CONTROL_RESET[4:0]);
        end else begin
            if (trigger) begin
                ctrl_q.reset_source_flag <= 1'b1;
            end
            if (sys_reset_q) begin
                ctrl_q.clock_monitor_enable <= 1'b0;
                ctrl_q.watchdog_enable <= 1'b0;
                ctrl_q.period_select_hi <= 1'b0;
                ctrl_q.period_select_lo <= 1'b0;
            end else if (wr_done && paddr == wdcm_pkg::ADDR_CONTROL) begin
                ctrl_q.clock_monitor_enable <= pwdata[wdcm_pkg::CME_POS];
                ctrl_q.watchdog_enable <= pwdata[wdcm_pkg::WDE_POS];
                // Writing zero leaves the period bits as they are.
                if (pwdata[wdcm_pkg::PSH_POS]) begin
                    ctrl_q.period_select_hi <= 1'b1;
                end
                if (pwdata[wdcm_pkg::PSL_POS]) begin
                    ctrl_q.period_select_lo <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Service sequence
    // ************************************************************
    assign svc_restart = wr_done && (paddr == wdcm_pkg::ADDR_SERVICE)
        && (pwdata[7:0] == wdcm_pkg::SERVICE_KEY_SECOND) && (svc_q == wdcm_pkg::WDCM_SVC_ARMED);

    // Only service writes and system reset move the sequence; reads and other registers leave it armed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_q <= wdcm_pkg::WDCM_SVC_IDLE;
        end else if (sys_reset_q) begin
            svc_q <= wdcm_pkg::WDCM_SVC_IDLE;
        end else if (wr_done && paddr == wdcm_pkg::ADDR_SERVICE) begin
            case (svc_q)
                wdcm_pkg::WDCM_SVC_IDLE: begin
                    if (pwdata[7:0] == wdcm_pkg::SERVICE_KEY_FIRST) begin
                        svc_q <= wdcm_pkg::WDCM_SVC_ARMED;
                    end
                end
                wdcm_pkg::WDCM_SVC_ARMED: begin
                    // Other bytes, including a repeated first key, keep it armed.
                    if (pwdata[7:0] == wdcm_pkg::SERVICE_KEY_SECOND) begin
                        svc_q <= wdcm_pkg::WDCM_SVC_IDLE;
                    end
                end
                default: svc_q <= wdcm_pkg::WDCM_SVC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    // Each step of the period code multiplies the base by four.
    assign wd_limit = 22'(BASE_DIV) << {ctrl_q.period_select_hi, ctrl_q.period_select_lo, 1'b0};
    assign wd_expire = ctrl_q.watchdog_enable && (wd_cnt_q == wd_limit - 22'h00_0001);

    // Count runs only while enabled; software must service in time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_q <= 22'h00_0000;
        end else if (sys_reset_q || !ctrl_q.watchdog_enable || svc_restart || wd_expire) begin
            wd_cnt_q <= 22'h00_0000;
        end else begin
            wd_cnt_q <= wd_cnt_q + 22'h00_0001;
        end
    end

    // ************************************************************
    // Clock monitor
    // ************************************************************
    // Reference passes three flops; an edge counts once the last two agree.
    // A fully stopped pclk cannot be seen from pclk itself; only slowing is caught.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
        end else begin
            ref_s1_q <= ref_clk_in;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
        end
    end

    assign ref_rise = (ref_s2_q == ref_s3_q) && ref_s3_q && !ref_lvl_q;
    assign clk_fail = ctrl_q.clock_monitor_enable && ref_rise
        && (gap_q < wdcm_pkg::CLKMON_MIN_CYCLES);

    // Gap counter saturates; held full while disabled so enabling cannot fault at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_lvl_q <= 1'b0;
            gap_q <= 16'hFFFF;
        end else begin
            if (ref_s2_q == ref_s3_q) begin
                ref_lvl_q <= ref_s3_q;
            end
            if (!ctrl_q.clock_monitor_enable) begin
                gap_q <= 16'hFFFF;
            end else if (ref_rise) begin
                gap_q <= 16'h0000;
            end else if (gap_q != 16'hFFFF) begin
                gap_q <= gap_q + 16'h0001;
            end
        end
    end

    // ************************************************************
    // System reset pulse
    // ************************************************************
    assign trigger = (wd_expire || clk_fail) && !sys_reset_q;

    // A fixed-length pulse gives the rest of the chip time to settle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_q <= 5'h00;
            sys_reset_q <= 1'b0;
        end else if (trigger) begin
            rst_cnt_q <= wdcm_pkg::SYSRST_CYCLES - 5'h01;
            sys_reset_q <= 1'b1;
        end else if (rst_cnt_q != 5'h00) begin
            rst_cnt_q <= rst_cnt_q - 5'h01;
        end else begin
            sys_reset_q <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign evt_set = (wd_expire ? wdcm_pkg::EVT_TIMEOUT : 3'h0)
        | (clk_fail ? wdcm_pkg::EVT_CLKFAIL : 3'h0)
        | (svc_restart ? wdcm_pkg::EVT_SERVICED : 3'h0);
    assign evt_clr = (wr_done && paddr == wdcm_pkg::ADDR_IRQ_CLEAR) ? pwdata[2:0] : 3'h0;

    // Set wins over a clear in the same cycle so no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 3'h0;
            enable_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            status_q <= (status_q & ~evt_clr) | evt_set;
            if (wr_done && paddr == wdcm_pkg::ADDR_IRQ_ENABLE) begin
                enable_q <= pwdata[2:0];
            end
            irq_q <= |(((status_q & ~evt_clr) | evt_set) & enable_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sys_reset_out = sys_reset_q;
    assign irq = irq_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_flag_on_reset: assert property (trigger |=> ctrl_q.reset_source_flag && sys_reset_q)
        else $error("reset cause did not set flag and reset");
    a_monitor_off_quiet: assert property ((!ctrl_q.clock_monitor_enable && !wd_expire
        && !sys_reset_q) |=> !sys_reset_q)
        else $error("reset raised with monitor off and no expiry");
    a_watchdog_off_quiet: assert property ((!ctrl_q.watchdog_enable && !clk_fail
        && !sys_reset_q) |=> !sys_reset_q)
        else $error("reset raised with watchdog off and no clock fault");
    a_period_sticky: assert property ($fell(ctrl_q.period_select_hi)
        || $fell(ctrl_q.period_select_lo) |-> $past(sys_reset_q))
        else $error("period select cleared without system reset");
    a_timeout_reset: assert property ((ctrl_q.watchdog_enable && !sys_reset_q
        && wd_cnt_q == wd_limit - 22'h00_0001) |=> sys_reset_q ##0 status_q[0])
        else $error("expiry did not reset system");
    a_service_restart: assert property ((svc_restart && !sys_reset_q
        && ctrl_q.watchdog_enable) |=> wd_cnt_q == 22'h00_0000 ##1 wd_cnt_q == 22'h00_0001)
        else $error("service sequence did not restart count");
    a_pending_kept: assert property ((svc_q == wdcm_pkg::WDCM_SVC_ARMED && !sys_reset_q
        && !(wr_done && paddr == wdcm_pkg::ADDR_SERVICE)) |=> svc_q == wdcm_pkg::WDCM_SVC_ARMED)
        else $error("pending service sequence lost");
    a_read_no_effect: assert property ((rd_done && paddr == wdcm_pkg::ADDR_SERVICE
        && !sys_reset_q) |=> $stable(svc_q))
        else $error("service read changed sequence state");
    a_reset_length: assert property ($rose(sys_reset_q) |-> sys_reset_q [*8] ##8 sys_reset_q
        ##1 !sys_reset_q)
        else $error("system reset pulse length wrong");
    a_apb_answer: assert property (access_go |=> pready_q ##1 !pready_q)
        else $error("APB answer not one cycle after access");
    // The answer carries data and error only in its own cycle.
    a_unmapped_err: assert property ((access_go && !addr_hit) |=> pslverr_q && pready_q)
        else $error("unmapped access gave no error response");
    a_read_data_zero: assert property (!pready_q |-> prdata_q == 32'h0000_0000)
        else $error("read data shown outside the answer cycle");

    // Power-on alone clears the flag; a one written to the low period bit is taken.
    a_flag_kept: assert property (ctrl_q.reset_source_flag
        |=> ctrl_q.reset_source_flag)
        else $error("reset-source flag cleared without power-on reset");
    a_period_write: assert property ((wr_done && paddr == wdcm_pkg::ADDR_CONTROL
        && pwdata[wdcm_pkg::PSL_POS] && !sys_reset_q) |=> ctrl_q.period_select_lo)
        else $error("period select write of one not taken");

    // Disabled parts, and the service sequence after system reset, must sit in their harmless idle state.
    a_gap_held: assert property (!ctrl_q.clock_monitor_enable
        |=> gap_q == 16'hFFFF)
        else $error("clock monitor gap not held while disabled");
    a_count_held_off: assert property (!ctrl_q.watchdog_enable
        |=> wd_cnt_q == 22'h00_0000)
        else $error("watchdog count moved while disabled");
    a_svc_cleared: assert property (sys_reset_q |=> svc_q == wdcm_pkg::WDCM_SVC_IDLE)
        else $error("service sequence kept through system reset");

    // The timeout status bit stays set until written off; the interrupt follows status and enables.
    a_status_sticky: assert property ((status_q[0] && !evt_clr[0]) |=> status_q[0])
        else $error("timeout status bit lost without a clear");
    a_irq_follows: assert property ($stable(enable_q) |-> irq_q == |(status_q & enable_q))
        else $error("interrupt level differs from enabled status");

    // Scenarios that the bench is expected to reach.
    c_timeout: cover property (wd_expire);
    c_clock_fail: cover property (clk_fail);
    c_service_done: cover property (svc_restart);
    c_unmapped_access: cover property (access_go && !addr_hit);
    c_armed_read: cover property (svc_q == wdcm_pkg::WDCM_SVC_ARMED && rd_done);

endmodule // wdcm_top

//--- wdcm_tb.sv
// Purpose: Self-checking bench for the watchdog and clock monitor block.
// Assumes: BASE_DIV shortened to 32 so every timeout fits in a short run.
// Notes:   Expectations come from an integer model of the control register; status is checked against fixed values.
`timescale 1ns/1ps
module testbench;
    // ************************************************************
    // Signals and model state
    // ************************************************************
    localparam int unsigned BDIV = 32; // Shortened base timeout, above one service round.
    logic pclk = 1'b0; // Bench clock.
    logic presetn = 1'b0; // Power-on reset, active low.
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
    logic [11:0] paddr = 12'h000; // APB address.
    logic [31:0] pwdata = 32'h00000000; // APB write data.
    logic [31:0] prdata; // APB read data.
    logic pready, pslverr, sys_reset_out, irq, sys_q; // Design outputs and edge helper.
    logic ref_clk_in = 1'b0; // Reference clock pin.
    int n_mismatch = 0, checked = 0, rst_count = 0, seed = 38414; // Bench counters.
    int ctl_m = 0; // Model of the control register.
    logic [31:0] rd_v; // Last read value.
    logic err_v; // Last error response.
    int n, m; // Cycle counts.

    wdcm_top #(.BASE_DIV(BDIV)) wdcm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
        .sys_reset_out(sys_reset_out), .irq(irq));

    // A free-running 50 MHz clock.
    initial begin
        forever #10 pclk = ~pclk;
    end

    // Count rising edges of the system reset request, so a missed or extra reset shows up.
    always @(posedge pclk) begin
        sys_q <= sys_reset_out;
        if (sys_reset_out === 1'b1 && sys_q !== 1'b1) begin
            rst_count <= rst_count + 1;
        end
    end

    // ************************************************************
    // Compare and bus tasks
    // ************************************************************
    // Exact comparison of a value against the model.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Range comparison, used for counts whose start edge depends on pipeline depth.
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checked++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // One APB transfer; entered just after a rising edge, holds until pready is sampled.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so the next call never reassigns psel in this time step.
        @(posedge pclk);
    endtask

    // Write, updating the control model when the control register is hit.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == wdcm_pkg::ADDR_CONTROL) ctl_m = (ctl_m & 32'h13) | (d & 32'h0F);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask

    // Wait for a system reset, returning the cycles waited, then check its length.
    task automatic wait_rst(output int cyc);
        cyc = 0;
        while (sys_reset_out !== 1'b1 && cyc < 3000) begin
            @(posedge pclk);
            cyc++;
        end
        m = 0;
        while (sys_reset_out === 1'b1 && m < 40) begin
            @(posedge pclk);
            m++;
        end
        chk(m, 16);
        ctl_m = 32'h10;
    endtask

    // Toggle the reference pin every half cycles of pclk.
    task automatic ref_run(input int edges, input int half);
        repeat (edges) begin
            repeat (half) @(posedge pclk);
            ref_clk_in <= ~ref_clk_in;
        end
        repeat (30) @(posedge pclk);
    endtask

    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Guards against a hang; the whole sequence needs well under 20000 cycles.
    initial begin
        #(20 * 20000);
        n_mismatch++;
        final_report();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(wdcm_pkg::ADDR_CONTROL, 32'h00);
        rd(wdcm_pkg::ADDR_SERVICE, 32'h00);
        apb(1'b1, 12'hF00 | 12'($random(seed) & 32'hFC), $random(seed));
        chk(err_v, 1'b1);
        // Period bits are set by ones and survive a write of zero.
        wr(wdcm_pkg::ADDR_CONTROL, 32'h01);
        wr(wdcm_pkg::ADDR_CONTROL, 32'h00);
        rd(wdcm_pkg::ADDR_CONTROL, 32'h01);
        wr(wdcm_pkg::ADDR_CONTROL, 32'h02);
        rd(wdcm_pkg::ADDR_CONTROL, 32'h03);
        // Fast reference with the monitor off must not reset; slow with it on must not either.
        ref_run(8, 4);
        chk(rst_count, 0);
        wr(wdcm_pkg::ADDR_CONTROL, 32'h08);
        ref_run(6, 20);
        chk(rst_count, 0);
        ref_run(8, 4);
        chk(rst_count, 1);
        rd(wdcm_pkg::ADDR_CONTROL, 32'h10);
        rd(wdcm_pkg::ADDR_IRQ_STATUS, 32'h2);
        wr(wdcm_pkg::ADDR_IRQ_CLEAR, 32'h7);
        // Each period code, with the interrupt masked on the last one.
        for (int s = 0; s < 4; s++) begin
            wr(wdcm_pkg::ADDR_IRQ_ENABLE, (s < 3) ? 32'h1 : 32'h0);
            wr(wdcm_pkg::ADDR_CONTROL, 32'h04 | s);
            wait_rst(n);
            chk_rng(n, (BDIV << (2 * s)) - 2, (BDIV << (2 * s)) + 3);
            rd(wdcm_pkg::ADDR_CONTROL, ctl_m);
            rd(wdcm_pkg::ADDR_IRQ_STATUS, 32'h1);
            chk(irq, (s < 3) ? 1'b1 : 1'b0);
            wr(wdcm_pkg::ADDR_IRQ_CLEAR, 32'h7);
            rd(wdcm_pkg::ADDR_IRQ_STATUS, 32'h0);
            chk(irq, 1'b0);
        end
        // Disabled watchdog never expires.
        repeat (40) @(posedge pclk);
        chk(rst_count, 5);
        // Service with other traffic between the two bytes keeps the block out of reset.
        wr(wdcm_pkg::ADDR_IRQ_ENABLE, 32'h4);
        wr(wdcm_pkg::ADDR_CONTROL, 32'h04);
        repeat (6) begin
            wr(wdcm_pkg::ADDR_SERVICE, 32'h55);
            apb(1'b1, 12'hF00 | 12'($random(seed) & 32'hFC), $random(seed));
            rd(wdcm_pkg::ADDR_SERVICE, 32'h00);
            wr(wdcm_pkg::ADDR_SERVICE, 32'hAA);
        end
        chk(rst_count, 5);
        rd(wdcm_pkg::ADDR_IRQ_STATUS, 32'h4);
        chk(irq, 1'b1);
        // Bytes in the wrong order do not restart the count.
        wr(wdcm_pkg::ADDR_SERVICE, 32'hAA);
        wr(wdcm_pkg::ADDR_SERVICE, 32'h55);
        wait_rst(n);
        chk(rst_count, 6);
        rd(wdcm_pkg::ADDR_CONTROL, 32'h10);
        final_report();
    end
endmodule // testbench
